// ### design/ebwr_busclk.sv
// Purpose: Bus clock output generator with rising-edge look-ahead.
// Assumes: CLK_IN is the timing clock; the bus clock toggles from a flop.
// Notes:   rise_next tells the sequencer that the coming edge raises the bus clock.
`timescale 1ns/1ps
`default_nettype none

module ebwr_busclk (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rstn_in,
	// Configuration
	input  wire logic half_rate_in,
	// Outputs
	output logic      bus_clock_out,
	output logic      rise_next_out
);

	logic phase;
	logic next_phase;
	logic next_bus_clock;
	logic toggle_now;

	always_comb begin
		toggle_now     = half_rate_in ? phase : 1'b1;
		next_phase     = half_rate_in ? ~phase : 1'b0;
		next_bus_clock = toggle_now ? ~bus_clock_out : bus_clock_out;
		rise_next_out  = toggle_now & ~bus_clock_out;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			phase         <= 1'b0;
			bus_clock_out <= ebwr_pkg::BUS_CLK_RESET;
		end else begin
			phase         <= next_phase;
			bus_clock_out <= next_bus_clock;
		end
	end

endmodule

`default_nettype wire

// ### design/ebwr_ctrl.sv
// Purpose: Write-cycle sequencer of the external parallel bus, with wait extension.
// Assumes: Requests and configuration are synchronous to CLK_IN; ready is pre-synchronised.
// Notes:   Phase lengths are latched when a request is accepted.
`timescale 1ns/1ps
`default_nettype none

module ebwr_ctrl #(
	parameter int ADDR_W  = ebwr_pkg::ADDR_W,
	parameter int DATA_W  = ebwr_pkg::DATA_W,
	parameter int PHASE_W = ebwr_pkg::PHASE_W
) (
	// Clock and reset
	input  wire logic               CLK_IN,
	input  wire logic               RSTN_IN,
	// Write request
	input  wire logic               WR_REQ_IN,
	input  wire logic [ADDR_W-1:0]  WR_ADDR_IN,
	input  wire logic [DATA_W-1:0]  WR_DATA_IN,
	input  wire logic [1:0]         WR_LANE_IN,
	output logic                    WR_ACK_OUT,
	output logic                    WR_DONE_OUT,
	output logic                    BUSY_OUT,
	// Configuration
	input  wire logic               BUS32_IN,
	input  wire logic               READY_ENABLE_IN,
	input  wire logic               READY_SAMPLE_MODE_IN,
	input  wire logic               TIMING_DOUBLE_IN,
	input  wire logic               BUS_CLOCK_HALF_IN,
	input  wire logic [PHASE_W-1:0] WRITE_LEAD_CYCLES_IN,
	input  wire logic [PHASE_W-1:0] WRITE_ACTIVE_CYCLES_IN,
	input  wire logic [PHASE_W-1:0] WRITE_TRAIL_CYCLES_IN,
	// External bus
	output logic                    BUS_CLOCK_OUT,
	output logic                    ZONE_SELECT_N_OUT,
	output logic [ADDR_W-1:0]       ADDR_OUT,
	output logic                    WRITE_STROBE_LO_N_OUT,
	output logic                    WRITE_STROBE_HI_N_OUT,
	output logic                    READ_WRITE_DIR_OUT,
	output logic [DATA_W-1:0]       EXT_DATA_BUS_OUT,
	output logic                    EXT_DATA_BUS_OE_N_OUT,
	input  wire logic               WAIT_READY_IN
);

	localparam int CW = PHASE_W + 1;

	// ----------------------------------------------------------------
	// Bus clock
	// ----------------------------------------------------------------
	logic rise_next;

	ebwr_busclk u_busclk (
		.clk_in        (CLK_IN),
		.rstn_in       (RSTN_IN),
		.half_rate_in  (BUS_CLOCK_HALF_IN),
		.bus_clock_out (BUS_CLOCK_OUT),
		.rise_next_out (rise_next)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ebwr_pkg::ebwr_state_e state;
	ebwr_pkg::ebwr_state_e next_state;
	logic [CW-1:0]         cnt;
	logic [CW-1:0]         next_cnt;
	logic                  rdy_seen;
	logic                  next_rdy_seen;
	logic [ADDR_W-1:0]     addr_q;
	logic [ADDR_W-1:0]     next_addr_q;
	logic [DATA_W-1:0]     data_q;
	logic [DATA_W-1:0]     next_data_q;
	logic [1:0]            lane_q;
	logic [1:0]            next_lane_q;
	logic [CW-1:0]         act_len;
	logic [CW-1:0]         next_act_len;
	logic [CW-1:0]         trail_len;
	logic [CW-1:0]         next_trail_len;

	// Output flops and their next values.
	logic                  next_zone_n;
	logic [ADDR_W-1:0]     next_addr;
	logic                  next_we_lo_n;
	logic                  next_we_hi_n;
	logic                  next_dir;
	logic [DATA_W-1:0]     next_data;
	logic                  next_oe_n;
	logic                  next_done;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// A programmed zero is treated as one cycle so every phase exists.
	function automatic logic [CW-1:0] phase_len(input logic [PHASE_W-1:0] raw,
						    input logic dbl);
		logic [CW-1:0] base;
		base = {1'b0, raw};
		if (base == ebwr_pkg::CNT_ZERO) begin
			base = ebwr_pkg::CNT_ONE;
		end
		if (dbl) begin
			base = {base[CW-2:0], 1'b0};
		end
		return base;
	endfunction

	logic          in_access;
	logic          strobe_phase;
	logic          sample_now;
	logic          async_mode;
	logic [CW-1:0] lead_len;

	// ----------------------------------------------------------------
	// Sequencer next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state     = state;
		next_cnt       = cnt;
		next_rdy_seen  = rdy_seen;
		next_addr_q    = addr_q;
		next_data_q    = data_q;
		next_lane_q    = lane_q;
		next_act_len   = act_len;
		next_trail_len = trail_len;
		next_done      = 1'b0;
		WR_ACK_OUT     = 1'b0;
		sample_now     = 1'b0;
		async_mode     = (READY_SAMPLE_MODE_IN == ebwr_pkg::MODE_ASYNC);
		lead_len       = phase_len(WRITE_LEAD_CYCLES_IN, TIMING_DOUBLE_IN);
		case (state)
			ebwr_pkg::ST_IDLE: begin
				if (WR_REQ_IN) begin
					WR_ACK_OUT     = 1'b1;
					next_addr_q    = WR_ADDR_IN;
					next_data_q    = WR_DATA_IN;
					next_lane_q    = WR_LANE_IN;
					next_act_len   = phase_len(WRITE_ACTIVE_CYCLES_IN, TIMING_DOUBLE_IN);
					next_trail_len = phase_len(WRITE_TRAIL_CYCLES_IN, TIMING_DOUBLE_IN);
					next_cnt       = lead_len - ebwr_pkg::CNT_ONE;
					// Lead may only open on a rising bus clock edge.
					next_state     = rise_next ? ebwr_pkg::ST_LEAD : ebwr_pkg::ST_ALIGN;
				end
			end
			ebwr_pkg::ST_ALIGN: begin
				if (rise_next) begin
					next_state = ebwr_pkg::ST_LEAD;
				end
			end
			ebwr_pkg::ST_LEAD: begin
				if (cnt == ebwr_pkg::CNT_ZERO) begin
					next_state    = ebwr_pkg::ST_ACTIVE;
					next_cnt      = act_len - ebwr_pkg::CNT_ONE;
					next_rdy_seen = 1'b0;
				end else begin
					next_cnt = cnt - ebwr_pkg::CNT_ONE;
				end
			end
			ebwr_pkg::ST_ACTIVE: begin
				// Synchronous mode samples in the last active cycle; asynchronous
				// mode starts two cycles earlier and keeps sampling.
				if (READY_ENABLE_IN && !rdy_seen) begin
					sample_now = async_mode ? (cnt <= ebwr_pkg::ASYNC_EARLY)
								: (cnt == ebwr_pkg::CNT_ZERO);
				end
				if (sample_now && WAIT_READY_IN) begin
					next_rdy_seen = 1'b1;
				end
				if (cnt == ebwr_pkg::CNT_ZERO) begin
					if (!READY_ENABLE_IN || next_rdy_seen) begin
						next_state = ebwr_pkg::ST_TRAIL;
						next_cnt   = trail_len - ebwr_pkg::CNT_ONE;
					end else begin
						next_state = ebwr_pkg::ST_WAIT;
					end
				end else begin
					next_cnt = cnt - ebwr_pkg::CNT_ONE;
				end
			end
			ebwr_pkg::ST_WAIT: begin
				if (!rdy_seen) begin
					// Resample once per timing cycle while ready stays low.
					sample_now = 1'b1;
					if (WAIT_READY_IN) begin
						if (async_mode) begin
							// The asynchronous sample leads the strobe end by
							// two cycles, so finish the remaining tail.
							next_rdy_seen = 1'b1;
							next_cnt      = ebwr_pkg::ASYNC_TAIL;
						end else begin
							next_state = ebwr_pkg::ST_TRAIL;
							next_cnt   = trail_len - ebwr_pkg::CNT_ONE;
						end
					end
				end else if (cnt == ebwr_pkg::CNT_ZERO) begin
					next_state = ebwr_pkg::ST_TRAIL;
					next_cnt   = trail_len - ebwr_pkg::CNT_ONE;
				end else begin
					next_cnt = cnt - ebwr_pkg::CNT_ONE;
				end
			end
			ebwr_pkg::ST_TRAIL: begin
				if (cnt == ebwr_pkg::CNT_ZERO) begin
					// Zone select ends with the trail phase.
					next_state = ebwr_pkg::ST_IDLE;
					next_done  = 1'b1;
				end else begin
					next_cnt = cnt - ebwr_pkg::CNT_ONE;
				end
			end
			default: begin
				next_state = ebwr_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Pin next values
	// ----------------------------------------------------------------
	// Pins are computed from the next state so they switch on the same
	// edge as the phase, keeping every pin a clean flop output.
	always_comb begin
		in_access    = (next_state == ebwr_pkg::ST_LEAD) || (next_state == ebwr_pkg::ST_ACTIVE)
			    || (next_state == ebwr_pkg::ST_WAIT) || (next_state == ebwr_pkg::ST_TRAIL);
		strobe_phase = (next_state == ebwr_pkg::ST_ACTIVE) || (next_state == ebwr_pkg::ST_WAIT);

		// Alignment and idle cycles leave zone select, direction and strobes inactive.
		next_zone_n  = in_access ? 1'b0 : ebwr_pkg::LEVEL_INACTIVE;
		next_dir     = in_access ? ebwr_pkg::DIR_WRITE : ebwr_pkg::DIR_READ;

		// Address stays put between accesses with only bit 0 forced high.
		if (in_access) begin
			next_addr = next_addr_q;
		end else begin
			next_addr = {ADDR_OUT[ADDR_W-1:1], ebwr_pkg::ADDR0_IDLE};
		end

		next_we_lo_n = ebwr_pkg::LEVEL_INACTIVE;
		if (strobe_phase && ((next_lane_q & ebwr_pkg::LANE_LO) != 2'h0 || !BUS32_IN)) begin
			next_we_lo_n = 1'b0;
		end

		// On a 16-bit bus the upper strobe pin carries address bit 0.
		if (BUS32_IN) begin
			next_we_hi_n = (strobe_phase && (next_lane_q & ebwr_pkg::LANE_HI) != 2'h0)
				     ? 1'b0 : ebwr_pkg::LEVEL_INACTIVE;
		end else begin
			next_we_hi_n = next_addr[0];
		end

		// Drive starts with the strobes, holds through trail, and lasts one
		// cycle after direction goes high so the last data is not cut.
		if (strobe_phase || (next_state == ebwr_pkg::ST_TRAIL)
		    || (state == ebwr_pkg::ST_TRAIL)) begin
			next_oe_n = ebwr_pkg::OE_ON_N;
		end else begin
			next_oe_n = ebwr_pkg::OE_OFF_N;
		end
		next_data = (next_oe_n == ebwr_pkg::OE_ON_N) ? next_data_q : EXT_DATA_BUS_OUT;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state                 <= ebwr_pkg::ST_IDLE;
			cnt                   <= '0;
			rdy_seen              <= 1'b0;
			addr_q                <= '0;
			data_q                <= '0;
			lane_q                <= '0;
			act_len               <= '0;
			trail_len             <= '0;
			ZONE_SELECT_N_OUT     <= ebwr_pkg::LEVEL_INACTIVE;
			ADDR_OUT              <= {{(ADDR_W-1){1'b0}}, ebwr_pkg::ADDR0_IDLE};
			WRITE_STROBE_LO_N_OUT <= ebwr_pkg::LEVEL_INACTIVE;
			WRITE_STROBE_HI_N_OUT <= ebwr_pkg::LEVEL_INACTIVE;
			READ_WRITE_DIR_OUT    <= ebwr_pkg::DIR_READ;
			EXT_DATA_BUS_OUT      <= '0;
			EXT_DATA_BUS_OE_N_OUT <= ebwr_pkg::OE_OFF_N;
			WR_DONE_OUT           <= 1'b0;
		end else begin
			state                 <= next_state;
			cnt                   <= next_cnt;
			rdy_seen              <= next_rdy_seen;
			addr_q                <= next_addr_q;
			data_q                <= next_data_q;
			lane_q                <= next_lane_q;
			act_len               <= next_act_len;
			trail_len             <= next_trail_len;
			ZONE_SELECT_N_OUT     <= next_zone_n;
			ADDR_OUT              <= next_addr;
			WRITE_STROBE_LO_N_OUT <= next_we_lo_n;
			WRITE_STROBE_HI_N_OUT <= next_we_hi_n;
			READ_WRITE_DIR_OUT    <= next_dir;
			EXT_DATA_BUS_OUT      <= next_data;
			EXT_DATA_BUS_OE_N_OUT <= next_oe_n;
			WR_DONE_OUT           <= next_done;
		end
	end

	// The external side need not hold ready high until zone select rises; a
	// sampled high is latched, so a later drop is simply not looked at.
	assign BUSY_OUT = (state != ebwr_pkg::ST_IDLE);

endmodule

`default_nettype wire

// ### inc/ebwr_pkg.sv
// Purpose: Shared constants and types for the external bus write sequencer.
// Assumes: One clock, CLK_IN, which also serves as the interface timing clock.
// Notes:   Every number used by the logic is named here.
//
// Notes on behaviour
// - Lead phase starts on bus clock rising edge.
// - Alignment cycles drive all controls inactive.
// - Inactive cycles keep address, lowest line high.
// - Upper strobe only in 32-bit mode, else address.
// - Access start: zone select low, address valid.
// - Direction low for write, high at end.
// - Data driven and valid with strobe assertion.
// - Data held through the write trail phase.
// - Data released shortly after direction returns high.
// - Synchronous: first ready sample after lead plus active.
// - Synchronous: low sample extends, resample every cycle.
// - Asynchronous: first sample two cycles earlier.
// - Asynchronous: low sample extends, resample every cycle.

package ebwr_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W      = 20;
	localparam int DATA_W      = 32;
	localparam int PHASE_W     = 4;
	localparam int CNT_W       = PHASE_W + 1;

	// ----------------------------------------------------------------
	// Encodings and timing
	// ----------------------------------------------------------------
	localparam logic       MODE_SYNC   = 1'b0;
	localparam logic       MODE_ASYNC  = 1'b1;
	localparam logic [CNT_W-1:0] ASYNC_EARLY  = 5'h02;
	localparam logic [CNT_W-1:0] ASYNC_TAIL   = 5'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO     = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE      = 5'h01;
	localparam logic       LEVEL_INACTIVE = 1'b1;
	localparam logic       ADDR0_IDLE  = 1'b1;
	localparam logic       DIR_READ    = 1'b1;
	localparam logic       DIR_WRITE   = 1'b0;
	localparam logic       OE_ON_N     = 1'b0;
	localparam logic       OE_OFF_N    = 1'b1;
	localparam logic       BUS_CLK_RESET = 1'b0;
	localparam logic [1:0] LANE_LO     = 2'h1;
	localparam logic [1:0] LANE_HI     = 2'h2;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ALIGN,
		ST_LEAD,
		ST_ACTIVE,
		ST_WAIT,
		ST_TRAIL
	} ebwr_state_e;

endpackage

// ### sim/ebwr_ctrl_test.sv
// Purpose: Directed write scenarios for the external bus write sequencer.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Phase lengths of zero are expected to behave as one cycle.
`timescale 1ns/1ps
`default_nettype none
module ebwr_ctrl_test;
	logic clk, rstn, req, en, md, b32, hf, ack, done, bclk, zone_n, lo_n, hi_n, dir, oe_n, rdy;
	logic td, busy;
	logic [19:0] addr, a_out;
	logic [31:0] data, d_out, seen;
	logic [3:0]  lead, act, trail, wlen;
	int error_cnt = 0;
	int checks_done = 0;
	ebwr_ctrl uut (.CLK_IN(clk), .RSTN_IN(rstn), .WR_REQ_IN(req), .WR_ADDR_IN(addr),
		.WR_DATA_IN(data), .WR_LANE_IN(2'h3), .WR_ACK_OUT(ack), .WR_DONE_OUT(done),
		.BUSY_OUT(busy), .BUS32_IN(b32), .READY_ENABLE_IN(en), .READY_SAMPLE_MODE_IN(md),
		.TIMING_DOUBLE_IN(td), .BUS_CLOCK_HALF_IN(hf), .WRITE_LEAD_CYCLES_IN(lead),
		.WRITE_ACTIVE_CYCLES_IN(act), .WRITE_TRAIL_CYCLES_IN(trail), .BUS_CLOCK_OUT(bclk),
		.ZONE_SELECT_N_OUT(zone_n), .ADDR_OUT(a_out), .WRITE_STROBE_LO_N_OUT(lo_n),
		.WRITE_STROBE_HI_N_OUT(hi_n), .READ_WRITE_DIR_OUT(dir), .EXT_DATA_BUS_OUT(d_out),
		.EXT_DATA_BUS_OE_N_OUT(oe_n), .WAIT_READY_IN(rdy));
	ebwr_slave mem (.clk_in(clk), .zone_select_n_in(zone_n), .strobe_n_in(lo_n),
		.oe_n_in(oe_n), .data_in(d_out), .wait_in(wlen), .ready_out(rdy), .seen_out(seen));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One write; expected lengths follow from the phases and the slave's ready delay.
	task automatic wr(input logic [19:0] a, input logic [31:0] d, input int l, ac, t,
			input logic e, m, w32, h, input logic [3:0] w);
		int el, ea, et, ex, zl, sl, sh, n;
		el = (l == 0) ? 1 : l;
		ea = (ac == 0) ? 1 : ac;
		et = (t == 0) ? 1 : t;
		// Double timing stretches every phase, and so moves the ready samples too.
		if (td) begin
			el = el * 2;
			ea = ea * 2;
			et = et * 2;
		end
		ex = !e ? 0 : (m ? int'(w) - (el + ea - 3) : int'(w) - (el + ea - 1));
		if (ex < 0)
			ex = 0;
		{addr, data, lead, act, trail} = {a, d, 4'(l), 4'(ac), 4'(t)};
		{en, md, b32, hf, wlen, req} = {e, m, w32, h, w, 1'b1};
		#1;
		chk(32'(ack), 32'h1);
		@(posedge clk) #1 req = 1'b0;
		{zl, sl, sh, n} = {32'd0, 32'd0, 32'd0, 32'd0};
		while (zone_n === 1'b1 && n < 40) begin
			n++;
			@(posedge clk) #1;
		end
		chk(32'(a_out), 32'(a));
		chk(32'(busy), 32'h1);
		while (zone_n !== 1'b1 && zl < 99) begin
			zl++;
			if (lo_n === 1'b0)
				sl++;
			if (hi_n === 1'b0)
				sh++;
			@(posedge clk) #1;
		end
		chk(32'(done), 32'h1);
		chk(32'(busy), 32'h0);
		// On a narrow bus the upper strobe pin shows address bit 0 for the whole access.
		chk(sh, w32 ? ea + ex : (a[0] ? 0 : el + ea + et + ex));
		chk(zl, el + ea + et + ex);
		chk(sl, ea + ex);
		chk(seen, d);
	endtask
	task automatic t_plain;
		wr(20'h12340, 32'hDEADBEEF, 1, 3, 1, 0, 0, 1, 0, 4'h0);
		wr(20'h54321, 32'h0F0F5AA5, 2, 4, 3, 0, 0, 1, 0, 4'h0);
		$display("t_plain done");
	endtask
	task automatic t_sync;
		wr(20'h00102, 32'h13579BDF, 1, 3, 1, 1, 0, 1, 0, 4'h6);
		wr(20'h00204, 32'h2468ACE0, 1, 3, 2, 1, 0, 1, 0, 4'h0);
		$display("t_sync done");
	endtask
	task automatic t_async;
		wr(20'h00306, 32'hCAFEF00D, 1, 3, 1, 1, 1, 1, 0, 4'h0);
		wr(20'h00408, 32'h8BADF00D, 1, 3, 1, 1, 1, 1, 0, 4'h4);
		wr(20'h0050A, 32'h600DCAFE, 2, 5, 1, 1, 1, 1, 1, 4'h9);
		$display("t_async done");
	endtask
	task automatic t_off;
		wr(20'h0060C, 32'h11223344, 1, 3, 1, 0, 0, 1, 0, 4'hF);
		$display("t_off done");
	endtask
	task automatic t_narrow;
		wr(20'h0070E, 32'h0000A55A, 0, 0, 0, 0, 0, 0, 1, 4'h0);
		wr(20'h00711, 32'h00005AA5, 1, 3, 1, 1, 0, 0, 1, 4'h2);
		$display("t_narrow done");
	endtask
	task automatic t_double;
		td = 1'b1;
		wr(20'h00812, 32'hA5A5C3C3, 1, 2, 1, 1, 0, 1, 0, 4'h8);
		td = 1'b0;
		$display("t_double done");
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#50000;
		error_cnt++;
		close_out();
	end
	initial begin
		{rstn, req, en, md, b32, hf, td} = 7'b0000100;
		{addr, data, lead, act, trail, wlen} = '0;
		repeat (16) @(posedge clk);
		#1 rstn = 1'b1;
		@(posedge clk) #1;
		t_plain();
		t_sync();
		t_async();
		t_off();
		t_narrow();
		t_double();
		close_out();
	end
endmodule
`default_nettype wire

// ### sim/ebwr_properties.sv
// Purpose: Pin-level checks of the external bus write sequencer.
// Assumes: Configuration inputs change only while the sequencer is idle.
// Notes:   Strobe length is counted here because latched phase lengths are not visible.
`timescale 1ns/1ps
`default_nettype none
module ebwr_properties #(
	parameter int ADDR_W  = 20,
	parameter int DATA_W  = 32,
	parameter int PHASE_W = 4
) (
	// Clock, reset and configuration
	input wire logic               CLK_IN,
	input wire logic               RSTN_IN,
	input wire logic               BUS32_IN,
	input wire logic               READY_ENABLE_IN,
	input wire logic               READY_SAMPLE_MODE_IN,
	input wire logic               TIMING_DOUBLE_IN,
	input wire logic [PHASE_W-1:0] WRITE_ACTIVE_CYCLES_IN,
	// External bus
	input wire logic               BUS_CLOCK_OUT,
	input wire logic               ZONE_SELECT_N_OUT,
	input wire logic [ADDR_W-1:0]  ADDR_OUT,
	input wire logic               WRITE_STROBE_LO_N_OUT,
	input wire logic               WRITE_STROBE_HI_N_OUT,
	input wire logic               READ_WRITE_DIR_OUT,
	input wire logic [DATA_W-1:0]  EXT_DATA_BUS_OUT,
	input wire logic               EXT_DATA_BUS_OE_N_OUT,
	input wire logic               WAIT_READY_IN
);
	logic [7:0] scnt;
	logic [7:0] next_scnt;
	logic [7:0] act_len;
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	always_comb begin
		next_scnt = WRITE_STROBE_LO_N_OUT ? 8'h00 : scnt + 8'h01;
		act_len = (WRITE_ACTIVE_CYCLES_IN == '0) ? 8'h01 : 8'(WRITE_ACTIVE_CYCLES_IN);
		if (TIMING_DOUBLE_IN)
			act_len = act_len << 1;
	end
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN)
			scnt <= 8'h00;
		else
			scnt <= next_scnt;
	end
	chk_lead_rise: assert property ($fell(ZONE_SELECT_N_OUT) |-> $rose(BUS_CLOCK_OUT))
		else $error("access began off a bus clock rise");
	chk_idle_quiet: assert property (ZONE_SELECT_N_OUT |-> WRITE_STROBE_LO_N_OUT
		&& READ_WRITE_DIR_OUT && (!BUS32_IN || WRITE_STROBE_HI_N_OUT))
		else $error("control active outside an access");
	chk_dir_zone: assert property (READ_WRITE_DIR_OUT == ZONE_SELECT_N_OUT)
		else $error("direction line not tied to the access");
	chk_idle_addr: assert property (ZONE_SELECT_N_OUT |-> ADDR_OUT[0]
		&& $stable(ADDR_OUT[ADDR_W-1:1]))
		else $error("idle address not held");
	chk_narrow_addr: assert property (!BUS32_IN && !$past(BUS32_IN)
		|-> WRITE_STROBE_HI_N_OUT == ADDR_OUT[0])
		else $error("narrow bus upper strobe pin not the address line");
	chk_strobe_data: assert property (!WRITE_STROBE_LO_N_OUT |-> !EXT_DATA_BUS_OE_N_OUT)
		else $error("strobe low with data bus undriven");
	chk_trail_hold: assert property (!EXT_DATA_BUS_OE_N_OUT && $past(!EXT_DATA_BUS_OE_N_OUT)
		|-> $stable(EXT_DATA_BUS_OUT))
		else $error("write data changed while driven");
	chk_data_release: assert property ($rose(READ_WRITE_DIR_OUT)
		|-> !EXT_DATA_BUS_OE_N_OUT ##1 EXT_DATA_BUS_OE_N_OUT)
		else $error("data bus release late or early");
	chk_sync_ready: assert property ($rose(WRITE_STROBE_LO_N_OUT) && READY_ENABLE_IN
		&& READY_SAMPLE_MODE_IN == ebwr_pkg::MODE_SYNC |-> $past(WAIT_READY_IN))
		else $error("sync access ended without a high ready sample");
	chk_async_ready: assert property ($rose(WRITE_STROBE_LO_N_OUT) && READY_ENABLE_IN
		&& READY_SAMPLE_MODE_IN == ebwr_pkg::MODE_ASYNC |-> $past(WAIT_READY_IN, 3))
		else $error("async access ended without a high ready sample");
	chk_strobe_len: assert property ($rose(WRITE_STROBE_LO_N_OUT) |-> scnt >= act_len
		&& (READY_ENABLE_IN || scnt == act_len))
		else $error("strobe length differs from the active phase");
endmodule
bind ebwr_ctrl ebwr_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .PHASE_W(PHASE_W)) chk (
	.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .BUS32_IN(BUS32_IN),
	.READY_ENABLE_IN(READY_ENABLE_IN), .READY_SAMPLE_MODE_IN(READY_SAMPLE_MODE_IN),
	.TIMING_DOUBLE_IN(TIMING_DOUBLE_IN), .WRITE_ACTIVE_CYCLES_IN(WRITE_ACTIVE_CYCLES_IN),
	.BUS_CLOCK_OUT(BUS_CLOCK_OUT), .ZONE_SELECT_N_OUT(ZONE_SELECT_N_OUT), .ADDR_OUT(ADDR_OUT),
	.WRITE_STROBE_LO_N_OUT(WRITE_STROBE_LO_N_OUT), .WRITE_STROBE_HI_N_OUT(WRITE_STROBE_HI_N_OUT),
	.READ_WRITE_DIR_OUT(READ_WRITE_DIR_OUT), .EXT_DATA_BUS_OUT(EXT_DATA_BUS_OUT),
	.EXT_DATA_BUS_OE_N_OUT(EXT_DATA_BUS_OE_N_OUT), .WAIT_READY_IN(WAIT_READY_IN)
);
`default_nettype wire

// ### sim/ebwr_slave.sv
// Purpose: Model of the external memory that stretches writes with its ready line.
// Assumes: Ready is raised a set number of cycles after zone select falls.
// Notes:   Outside an access ready toggles, so a sequencer that samples it then is caught.
`timescale 1ns/1ps
`default_nettype none
module ebwr_slave (
	// Bus side
	input wire logic        clk_in,
	input wire logic        zone_select_n_in,
	input wire logic        strobe_n_in,
	input wire logic        oe_n_in,
	input wire logic [31:0] data_in,
	// Control and observation
	input wire logic [3:0]  wait_in,
	output logic            ready_out,
	output logic [31:0]     seen_out
);
	logic [3:0] cnt;
	logic       idle_pat;
	logic       strobe_q;
	initial begin
		cnt = 4'h0;
		idle_pat = 1'b0;
		strobe_q = 1'b1;
		seen_out = 32'h0;
	end
	always @(posedge clk_in) begin
		cnt <= zone_select_n_in ? 4'h0 : ((cnt == 4'hF) ? cnt : cnt + 4'h1);
		idle_pat <= ~idle_pat;
		strobe_q <= strobe_n_in;
		if (strobe_n_in && !strobe_q && !oe_n_in)
			seen_out <= data_in;
	end
	// Once high, ready stays high until zone select is released.
	assign ready_out = zone_select_n_in ? idle_pat : (cnt >= wait_in);
endmodule
`default_nettype wire
